// ### shared/tcl_pkg.sv
`default_nettype none
package tcl_pkg;
   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int IDX_W  = 6;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_CODING      = 6'h15;
   localparam logic [IDX_W-1:0] IDX_RESERVED    = 6'h16;
   localparam logic [IDX_W-1:0] IDX_DELAY       = 6'h17;
   localparam logic [IDX_W-1:0] IDX_MSG         = 6'h18;
   localparam logic [IDX_W-1:0] IDX_MSG_SLOTS   = 6'h1B;
   localparam logic [IDX_W-1:0] IDX_CLEAR_SLOTS = 6'h1C;
   localparam logic [IDX_W-1:0] IDX_SIG_CTRL    = 6'h1D;
   localparam logic [IDX_W-1:0] IDX_STATUS      = 6'h1E;

   // Coding and loopback control bit positions
   localparam int CB_RX_DEC = 7;
   localparam int CB_METAL  = 6;
   localparam int CB_TX_ENC = 5;
   localparam int CB_STUFF  = 4;
   localparam int CB_DIG    = 3;
   localparam int CB_REMOTE = 2;
   localparam int CB_BPLOOP = 1;
   localparam int CB_PAYLD  = 0;

   // Signaling control bit positions
   localparam int SC_RBS_EN = 0;
   localparam int SC_SIG_A  = 1;
   localparam int SC_SIG_B  = 2;

   // Reset values
   localparam logic [7:0]  RST_CODING = 8'h00;
   localparam logic [7:0]  RST_MSG    = 8'h00;
   localparam logic [23:0] RST_SLOTS  = 24'h000000;
   localparam logic [7:0]  RST_SIG    = 8'h00;

   // Frame geometry: 24 slots of 8 bits plus one framing bit
   localparam logic [4:0] F_SLOT      = 5'h18;
   localparam logic [2:0] LAST_BIT    = 3'h7;
   localparam logic [3:0] SF_LAST     = 4'hB;
   localparam logic [3:0] SIG_FRAME_A = 4'h5;
   localparam logic [3:0] SIG_FRAME_B = 4'hB;
   localparam logic [7:0] MAX_DELAY   = 8'hC0;
   localparam logic [7:0] IDLE_BYTE   = 8'hFF;
   localparam int STUFF_BIT = 1;
   localparam int LSB_BIT   = 0;

   // Code 000VB0VB by bit time
   localparam logic [7:0] SUB_MARK_T = 8'hD8;
   localparam logic [7:0] SUB_VIOL_T = 8'h48;
   // Same code, receive shift order
   localparam logic [7:0] SUB_MARK_SR = 8'h1B;
   localparam int SR_P3 = 4;
   localparam int SR_P4 = 3;
   localparam int SR_P6 = 1;
   localparam int SR_P7 = 0;

   // Line bit rate derived from the system clock
   localparam int CLK_HZ   = 20_000_000;
   localparam int LINE_HZ  = 1_544_000;
   localparam int DIV_W    = 4;
   localparam logic [DIV_W-1:0] LINE_DIV = DIV_W'(CLK_HZ / LINE_HZ - 1);

   // Line pair of one direction
   typedef struct packed {
      logic tip;
      logic ring;
   } tcl_line_t;
endpackage
`default_nettype wire

// ### rtl/tcl_coding_loop.sv
// Summary of operation
// - Receive decodes substitution codes to zero octets
// - Metallic loop ties receive pins to transmit
// - Transmit replaces zero octets with substitution code
// - Zero channels get bit 1 forced
// - Digital loop feeds transmit stream to receiver
// - Backplane output echoes delayed backplane input in digital or backplane loop
// - Remote loop retransmits received line pulses
// - Backplane loop routes input slots to output
// - Payload loop sends received slots to transmitter
// - Payload loop with signaling overwrites slot LSB
// - Clear channel bits disable robbed signaling
// - Delay write repositions transmit frame boundary once
// - Delay counts from slot one write to read
// - Delay stays below one frame
// - Message byte fills selected outgoing channels
// - Signaling bit into LSB every sixth frame
`timescale 1ns/1ps
`default_nettype none

// Elastic buffer toward the framer
module tcl_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   input  wire logic         out_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   // Whole buffer state
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
   } tcl_fifo_st_t;

   tcl_fifo_st_t s_r;   // Registered state
   tcl_fifo_st_t s_nxt; // Next state
   logic         push;  // Write accepted
   logic         pop;   // Read accepted

   assign in_ready  = s_r.cnt != (AW+1)'(DEPTH);
   assign out_valid = s_r.cnt != '0;
   assign out_data  = s_r.mem[s_r.rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_ready && out_valid;

   // Pointer and count update
   always_comb
   begin
      s_nxt = s_r;
      if (push)
      begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : AW'(s_r.wp + 1'b1);
      end
      if (pop)
         s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : AW'(s_r.rp + 1'b1);
      // Simultaneous push and pop keeps the count
      if (push && !pop)
         s_nxt.cnt = (AW+1)'(s_r.cnt + 1'b1);
      else if (pop && !push)
         s_nxt.cnt = (AW+1)'(s_r.cnt - 1'b1);
   end

   // State register
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end
endmodule

// Line coding, loops, delay, message
module tcl_coding_loop #(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   input  wire logic [tcl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [tcl_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic [7:0]                backplane_data_in,
   input  wire logic                      backplane_in_valid,
   output logic                           backplane_in_ready,
   output logic [7:0]                     backplane_data_out,
   output logic                           backplane_out_valid,
   input  wire tcl_pkg::tcl_line_t        rx_line,
   output tcl_pkg::tcl_line_t             tx_line
);
   import tcl_pkg::*;

   // Whole block state
   typedef struct packed {
      logic            awready;
      logic            wready;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arready;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
      logic            aw_have;
      logic [IDX_W-1:0] aw_idx;
      logic            w_have;
      logic [31:0]     w_data;
      logic [3:0]      w_strb;
      logic [7:0]      coding;
      logic [7:0]      msg;
      logic [23:0]     msg_slots;
      logic [23:0]     clear_slots;
      logic [7:0]      sig_ctrl;
      logic [DIV_W-1:0] div;
      logic            tick;
      logic [2:0]      bit_idx;
      logic [4:0]      slot;
      logic [3:0]      frame;
      logic [7:0]      delay_cnt;
      logic [7:0]      tx_byte;
      logic            tx_sub;
      logic            tx_pol;
      logic [7:0]      bp_byte;
      tcl_line_t       rx_m1;
      tcl_line_t       rx_m2;
      logic [7:0]      rx_pos_sr;
      logic [7:0]      rx_neg_sr;
      logic            rx_pol;
      logic            rx_oct_pol;
      logic [7:0]      rx_byte;
      tcl_line_t       tx_line;
      logic [7:0]      bp_out_data;
      logic            bp_out_valid;
   } tcl_state_t;

   tcl_state_t s_r;     // Registered state
   tcl_state_t s_nxt;   // Next state
   logic       fifo_pop;  // Framer takes a byte
   logic       fifo_val;  // Buffer holds a byte
   logic [7:0] fifo_dat;  // Oldest buffered byte

   // Backplane bytes wait here until their slot comes round
   tcl_fifo #(
      .W     (8),
      .DEPTH (FIFO_DEPTH)
   ) u_txbuf (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (backplane_in_valid),
      .in_data   (backplane_data_in),
      .in_ready  (backplane_in_ready),
      .out_ready (fifo_pop),
      .out_valid (fifo_val),
      .out_data  (fifo_dat)
   );

   // Buffer drained once per payload slot, never during a delay hold
   assign fifo_pop = s_r.tick && (s_r.delay_cnt == '0) && (s_r.bit_idx == '0)
                     && (s_r.slot != F_SLOT);

   assign s_axi_awready       = s_r.awready;
   assign s_axi_wready        = s_r.wready;
   assign s_axi_bvalid        = s_r.bvalid;
   assign s_axi_bresp         = s_r.bresp;
   assign s_axi_arready       = s_r.arready;
   assign s_axi_rvalid        = s_r.rvalid;
   assign s_axi_rdata         = s_r.rdata;
   assign s_axi_rresp         = s_r.rresp;
   assign backplane_data_out  = s_r.bp_out_data;
   assign backplane_out_valid = s_r.bp_out_valid;
   assign tx_line             = s_r.tx_line;

   // Register access, framing, coding and loop selection
   always_comb
   begin
      logic [IDX_W-1:0] ridx;   // Read index
      logic [7:0]       cur;    // Byte for the current slot
      logic [7:0]       sh;     // Current byte shifted to the bit
      logic             dbit;   // Data bit on the wire
      logic             mark;   // Pulse to send
      logic             viol;   // Pulse is a violation
      logic             pol;    // Polarity of this pulse
      logic             tpos;   // Encoded positive pulse
      logic             tneg;   // Encoded negative pulse
      logic             spos;   // Receiver positive sample
      logic             sneg;   // Receiver negative sample
      logic [7:0]       rpos;   // Receive octet, positive marks
      logic [7:0]       rneg;   // Receive octet, negative marks
      logic [7:0]       rbyte;  // Decoded receive octet
      ridx  = s_axi_araddr[ADDR_W-1:2];
      cur   = s_r.tx_byte;
      sh    = '0;
      dbit  = 1'b0;
      mark  = 1'b0;
      viol  = 1'b0;
      pol   = s_r.tx_pol;
      tpos  = 1'b0;
      tneg  = 1'b0;
      spos  = 1'b0;
      sneg  = 1'b0;
      rpos  = s_r.rx_pos_sr;
      rneg  = s_r.rx_neg_sr;
      rbyte = '0;
      s_nxt = s_r;
      s_nxt.bp_out_valid = 1'b0;

      // Two-stage synchroniser on the line pins
      s_nxt.rx_m1 = rx_line;
      s_nxt.rx_m2 = s_r.rx_m1;

      // Bit-rate enable
      s_nxt.tick = 1'b0;
      if (s_r.div == LINE_DIV)
      begin
         s_nxt.div  = '0;
         s_nxt.tick = 1'b1;
      end
      else
         s_nxt.div = DIV_W'(s_r.div + 1'b1);

      // Write response handshake frees both holding slots
      if (s_r.bvalid && s_axi_bready)
      begin
         s_nxt.bvalid  = 1'b0;
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have  = 1'b0;
      end
      if (s_r.awready && s_axi_awvalid)
      begin
         s_nxt.aw_have = 1'b1;
         s_nxt.aw_idx  = s_axi_awaddr[ADDR_W-1:2];
      end
      if (s_r.wready && s_axi_wvalid)
      begin
         s_nxt.w_have = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end

      // Commit a write once address and data are both held
      if (s_r.aw_have && s_r.w_have && !s_r.bvalid)
      begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp  = RESP_OKAY;
         case (s_r.aw_idx)
            IDX_CODING:
               if (s_r.w_strb[0])
                  s_nxt.coding = s_r.w_data[7:0];
            IDX_MSG:
               if (s_r.w_strb[0])
                  s_nxt.msg = s_r.w_data[7:0];
            IDX_SIG_CTRL:
               if (s_r.w_strb[0])
                  s_nxt.sig_ctrl = s_r.w_data[7:0];
            IDX_MSG_SLOTS:
               for (int i = 0; i < 3; i++)
                  if (s_r.w_strb[i])
                     s_nxt.msg_slots[i*8 +: 8] = s_r.w_data[i*8 +: 8];
            IDX_CLEAR_SLOTS:
               for (int i = 0; i < 3; i++)
                  if (s_r.w_strb[i])
                     s_nxt.clear_slots[i*8 +: 8] = s_r.w_data[i*8 +: 8];
            IDX_DELAY:
               // Hold the frame start this many bits
               if (s_r.w_strb[0])
               begin
                  s_nxt.delay_cnt = (s_r.w_data[7:0] > MAX_DELAY) ? MAX_DELAY
                                    : s_r.w_data[7:0];
                  s_nxt.bit_idx   = '0;
                  s_nxt.slot      = '0;
                  s_nxt.frame     = '0;
               end
            // Reserved and status accept writes silently
            IDX_RESERVED, IDX_STATUS: ;
            default:
               s_nxt.bresp = RESP_SLVERR;
         endcase
      end

      // Read channel; write-only and reserved words read zero
      if (s_r.rvalid && s_axi_rready)
         s_nxt.rvalid = 1'b0;
      if (s_r.arready && s_axi_arvalid)
      begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp  = RESP_OKAY;
         s_nxt.rdata  = '0;
         case (ridx)
            IDX_CODING:      s_nxt.rdata[7:0]  = s_r.coding;
            IDX_MSG:         s_nxt.rdata[7:0]  = s_r.msg;
            IDX_SIG_CTRL:    s_nxt.rdata[7:0]  = s_r.sig_ctrl;
            IDX_MSG_SLOTS:   s_nxt.rdata[23:0] = s_r.msg_slots;
            IDX_CLEAR_SLOTS: s_nxt.rdata[23:0] = s_r.clear_slots;
            IDX_STATUS:      s_nxt.rdata[9:0]  = {s_r.delay_cnt != '0, s_r.frame, s_r.slot};
            IDX_RESERVED, IDX_DELAY: ;
            default:         s_nxt.rresp = RESP_SLVERR;
         endcase
      end
      // One transaction per channel in flight keeps the slave simple
      s_nxt.awready = !s_nxt.aw_have;
      s_nxt.wready  = !s_nxt.w_have;
      s_nxt.arready = !s_nxt.rvalid;

      // Line side, one step per bit time
      if (s_r.tick && (s_r.delay_cnt != '0))
      begin
         // Boundary held back; line idles with no pulses
         s_nxt.delay_cnt = 8'(s_r.delay_cnt - 1'b1);
         s_nxt.tx_line   = '0;
      end
      else if (s_r.tick)
      begin
         // Slot byte at first bit of slot
         if ((s_r.bit_idx == '0) && (s_r.slot != F_SLOT))
         begin
            cur = fifo_val ? fifo_dat : IDLE_BYTE;
            s_nxt.bp_byte = cur;
            if (s_r.coding[CB_PAYLD])
               cur = s_r.rx_byte;
            if (s_r.msg_slots[s_r.slot])
               cur = s_r.msg;
            // Clear channel slots keep their LSB intact
            if (s_r.sig_ctrl[SC_RBS_EN] && !s_r.clear_slots[s_r.slot])
            begin
               if (s_r.frame == SIG_FRAME_A)
                  cur[LSB_BIT] = s_r.sig_ctrl[SC_SIG_A];
               else if (s_r.frame == SIG_FRAME_B)
                  cur[LSB_BIT] = s_r.sig_ctrl[SC_SIG_B];
            end
            if (s_r.coding[CB_STUFF] && (cur == '0))
               cur[STUFF_BIT] = 1'b1;
            s_nxt.tx_sub = s_r.coding[CB_TX_ENC] && (cur == '0);
         end
         s_nxt.tx_byte = cur;
         sh   = cur << s_r.bit_idx;
         dbit = (s_r.slot == F_SLOT) ? s_r.frame[0] : sh[7];

         // Bipolar encoding with substitution marks
         if (s_r.slot == F_SLOT)
            mark = dbit;
         else if (s_nxt.tx_sub)
         begin
            mark = SUB_MARK_T[s_r.bit_idx];
            viol = SUB_VIOL_T[s_r.bit_idx];
         end
         else
            mark = dbit;
         if (mark)
         begin
            // A violation repeats the last polarity
            pol = viol ? s_r.tx_pol : !s_r.tx_pol;
            s_nxt.tx_pol = pol;
         end
         tpos = mark && pol;
         tneg = mark && !pol;

         // Receiver sees the transmit stream in digital loop
         spos = s_r.coding[CB_DIG] ? tpos : s_r.rx_m2.tip;
         sneg = s_r.coding[CB_DIG] ? tneg : s_r.rx_m2.ring;

         // Transmit pins: remote loop resends line pulses
         if (s_r.coding[CB_REMOTE])
            s_nxt.tx_line = s_r.rx_m2;
         else
         begin
            s_nxt.tx_line.tip  = tpos;
            s_nxt.tx_line.ring = tneg;
         end

         // Receive octet assembly, framing bit skipped
         if (s_r.slot != F_SLOT)
         begin
            if (s_r.bit_idx == '0)
               s_nxt.rx_oct_pol = s_r.rx_pol;
            rpos = {s_r.rx_pos_sr[6:0], spos};
            rneg = {s_r.rx_neg_sr[6:0], sneg};
            s_nxt.rx_pos_sr = rpos;
            s_nxt.rx_neg_sr = rneg;
            if (spos || sneg)
               s_nxt.rx_pol = spos;
         end
         if ((s_r.bit_idx == LAST_BIT) && (s_r.slot != F_SLOT))
         begin
            rbyte = rpos | rneg;
            // Substitution code: V, B, V, B with correct polarities
            if (s_r.coding[CB_RX_DEC] && (rbyte == SUB_MARK_SR)
                && (rpos[SR_P3] == s_nxt.rx_oct_pol)
                && (rpos[SR_P4] != rpos[SR_P3])
                && (rpos[SR_P6] == rpos[SR_P4])
                && (rpos[SR_P7] != rpos[SR_P6]))
               rbyte = '0;
            s_nxt.rx_byte      = rbyte;
            s_nxt.bp_out_valid = 1'b1;
            // Backplane loop returns the slot's own input byte
            s_nxt.bp_out_data  = s_r.coding[CB_BPLOOP] ? s_r.bp_byte : rbyte;
         end

         // Bit, slot and frame counters
         if (s_r.slot == F_SLOT)
         begin
            s_nxt.slot    = '0;
            s_nxt.bit_idx = '0;
            s_nxt.frame   = (s_r.frame == SF_LAST) ? '0 : 4'(s_r.frame + 1'b1);
         end
         else if (s_r.bit_idx == LAST_BIT)
         begin
            s_nxt.bit_idx = '0;
            s_nxt.slot    = 5'(s_r.slot + 1'b1);
         end
         else
            s_nxt.bit_idx = 3'(s_r.bit_idx + 1'b1);
      end

      // Metallic loop overrides everything, every clock
      if (s_r.coding[CB_METAL])
         s_nxt.tx_line = s_r.rx_m2;
   end

   // State register with constant reset values
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_r             <= '0;
         s_r.coding      <= RST_CODING;
         s_r.msg         <= RST_MSG;
         s_r.msg_slots   <= RST_SLOTS;
         s_r.clear_slots <= RST_SLOTS;
         s_r.sig_ctrl    <= RST_SIG;
      end
      else
         s_r <= s_nxt;
   end
endmodule
`default_nettype wire

// ### dv/tcl_chk_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Bus timing and slot pulse
module tcl_chk #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic                       clock,
   input wire logic                       rst_n,
   input wire logic [tcl_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic                       s_axi_awvalid,
   input wire logic                       s_axi_awready,
   input wire logic                       s_axi_wvalid,
   input wire logic                       s_axi_wready,
   input wire logic [1:0]                 s_axi_bresp,
   input wire logic                       s_axi_bvalid,
   input wire logic                       s_axi_bready,
   input wire logic [tcl_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic                       s_axi_arvalid,
   input wire logic                       s_axi_arready,
   input wire logic [31:0]                s_axi_rdata,
   input wire logic [1:0]                 s_axi_rresp,
   input wire logic                       s_axi_rvalid,
   input wire logic                       s_axi_rready,
   input wire logic                       backplane_out_valid
);
   import tcl_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   logic wr_go; // Address and data taken together
   logic rd_go; // Read address taken
   assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   // Both held at the take edge, committed one edge later
   chk_write_answer:
      assert property (wr_go |-> ##2 s_axi_bvalid) else $error("write answer late");
   chk_bresp_stands:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   chk_bvalid_drops:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
   chk_read_answer:
      assert property (rd_go |=> s_axi_rvalid) else $error("read answer late");
   chk_rdata_stands:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   chk_read_blocked:
      assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read taken");
   chk_wr_unmapped:
      assert property (wr_go && s_axi_awaddr[7:2] > IDX_STATUS |-> ##2 s_axi_bresp == RESP_SLVERR)
      else $error("unmapped write not refused");
   chk_rd_unmapped:
      assert property (rd_go && s_axi_araddr[7:2] > IDX_STATUS |=> s_axi_rresp == RESP_SLVERR
         && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
   chk_wo_reads_zero:
      assert property (rd_go && (s_axi_araddr[7:2] == IDX_DELAY
         || s_axi_araddr[7:2] == IDX_RESERVED)
         |=> s_axi_rdata == 32'h0 && s_axi_rresp == RESP_OKAY) else $error("hidden reg read");
   chk_slot_pulse:
      assert property (backplane_out_valid |=> !backplane_out_valid [*8])
      else $error("slot pulse too long");
endmodule
bind tcl_coding_loop tcl_chk #(.FIFO_DEPTH(FIFO_DEPTH)) tcl_chk_inst (.*);
`default_nettype wire

// ### dv/tcl_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far end: quiet, or random alternating marks
module tcl_line_model (
   input  wire logic          clock,
   input  wire logic          rst_n,
   input  wire logic          noisy,
   output tcl_pkg::tcl_line_t rx_line
);
   import tcl_pkg::*;
   logic pol_r; // Polarity of the last mark
   // New mark or none each clock
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_line <= '0;
         pol_r   <= 1'b0;
      end
      else if (noisy && $urandom_range(1) == 1)
      begin
         rx_line <= pol_r ? 2'b01 : 2'b10;
         pol_r   <= !pol_r;
      end
      else
         rx_line <= '0; // No pulse reads zero on both pins
   end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench
module tb_top;
   import tcl_pkg::*;
   logic clock, rst_n, noisy, ok, hit;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, v;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] backplane_data_in, backplane_data_out, b;
   logic backplane_in_valid, backplane_in_ready, backplane_out_valid;
   tcl_line_t rx_line, tx_line, rxh[48], txh[48];
   int n_fail = 0, checks = 0, cyc = 0;
   logic [7:0] got[$], sent[$]; // Bytes seen, bytes expected
   tcl_coding_loop #(.FIFO_DEPTH(8)) tcl_coding_loop_inst (.*);
   tcl_line_model tcl_line_model_inst (.*);
   // 20 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // Gather non-idle bytes
   always @(posedge clock)
      if (backplane_out_valid === 1'b1 && backplane_data_out !== IDLE_BYTE)
         got.push_back(backplane_data_out);
   // Hang guard
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_fail++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Write, address and data together
   task automatic wr(input logic [5:0] i, input logic [31:0] w);
      @(posedge clock);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= w;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] i);
      @(posedge clock);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic push(input logic [7:0] x);
      @(posedge clock);
      backplane_data_in <= x;
      backplane_in_valid <= 1'b1;
      do @(posedge clock); while (backplane_in_ready !== 1'b1);
      backplane_in_valid <= 1'b0;
   endtask
   // Zero octet after coding
   function automatic logic [7:0] exp_byte(input logic [7:0] x, input logic [7:0] c);
      if (x != 8'h00) return x;
      if (c[CB_STUFF]) return 8'h01 << STUFF_BIT;
      if (c[CB_TX_ENC] && !c[CB_RX_DEC]) return 8'h1B;
      return 8'h00;
   endfunction
   task automatic match();
      foreach (sent[i]) cmp(got[i], sent[i]);
   endtask
   // Bytes through the looped line
   task automatic stream(input logic [7:0] c);
      wr(IDX_CODING, {24'h0, c});
      repeat (300) @(posedge clock);
      got.delete();
      sent.delete();
      for (int i = 0; i < 6; i++)
      begin
         b = (i % 3 == 1) ? 8'h00 : 8'($urandom_range(254));
         sent.push_back(exp_byte(b, c));
         push(b);
      end
      repeat (1200) @(posedge clock);
      match();
   endtask
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, backplane_data_in} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {backplane_in_valid, noisy, rst_n} = '0;
      s_axi_wstrb = 4'hF;
      void'($urandom(32'h78829065));
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      // Reset, hidden, unmapped
      rd(IDX_CODING);
      cmp(d, {24'h0, RST_CODING});
      rd(IDX_DELAY);
      cmp(d, 32'h0);
      wr(IDX_RESERVED, 32'hFF);
      rd(IDX_RESERVED);
      cmp(d, 32'h0);
      wr(6'h3F, 32'h1);
      cmp(r, RESP_SLVERR);
      rd(6'h3F);
      cmp(r, RESP_SLVERR);
      repeat (4)
      begin
         v = $urandom();
         wr(IDX_MSG, v);
         rd(IDX_MSG);
         cmp(d, {24'h0, v[7:0]});
      end
      stream(8'h08);
      stream(8'h18);
      stream(8'h28);
      stream(8'hA8);
      // Delay hold, then clamp
      wr(IDX_CODING, 32'h1 << CB_BPLOOP);
      wr(IDX_DELAY, 32'h0F);
      rd(IDX_STATUS);
      cmp(d[9], 1'b1);
      repeat (15 * (LINE_DIV + 1) + 40) @(posedge clock);
      rd(IDX_STATUS);
      cmp(d[9], 1'b0);
      wr(IDX_DELAY, 32'hFF);
      got.delete();
      sent.delete();
      repeat (8)
      begin
         b = 8'($urandom_range(254));
         sent.push_back(b);
         push(b);
      end
      @(posedge clock);
      cmp(backplane_in_ready, 1'b0);
      repeat (200 * (LINE_DIV + 1)) @(posedge clock);
      rd(IDX_STATUS);
      cmp(d[9], 1'b0);
      repeat (1400) @(posedge clock);
      match();
      // Message byte in selected slots, first and third bytes checked
      v = $urandom_range(254);
      wr(IDX_MSG, v);
      wr(IDX_MSG_SLOTS, 32'hFFFFFF);
      wr(IDX_CODING, 32'h1 << CB_DIG);
      repeat (400) @(posedge clock);
      got.delete();
      repeat (400) @(posedge clock);
      cmp(got[0], v[7:0]);
      cmp(got[2], v[7:0]);
      wr(IDX_MSG_SLOTS, 32'h0);
      // Metallic loop, small lag; no build-out to set here
      wr(IDX_CODING, 32'h1 << CB_METAL);
      noisy <= 1'b1;
      for (int i = 0; i < 48; i++)
      begin
         @(posedge clock);
         rxh[i] = rx_line;
         txh[i] = tx_line;
      end
      noisy <= 1'b0;
      ok = 1'b0;
      for (int l = 1; l < 5; l++)
      begin
         hit = 1'b1;
         for (int i = 8; i < 48; i++) if (txh[i] !== rxh[i - l]) hit = 1'b0;
         ok = ok | hit;
      end
      cmp(ok, 1'b1);
      end_sim();
   end
endmodule
`default_nettype wire
